// *** src/dcd_top.sv ***
// Debug command decoder: parses command bytes from the serial layer,
// gates them by debug mode and read protect, answers reads, holds the
// debugger registers, and hands memory-type commands to a neighbour.
// Assumes the serial layer delivers bytes on pclk and reports line errors.
`timescale 1ns/1ps
`default_nettype none
module dcd_top
	import dcd_pkg::*;
#(
	parameter logic [15:0] REV_WORD = 16'h0100 // Arbitrary value
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [dcd_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Received bytes from the serial layer
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_err,
	// Reply bytes to the serial layer
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	output logic break_oe,
	// Serial layer state
	input wire logic [15:0] baud_reload,
	output logic [7:0] lcr,
	// Hand-off of memory-type commands
	output logic fwd_valid,
	output logic [7:0] fwd_cmd,
	output logic fwd_enable,
	output logic fwd_periph_only,
	input wire logic fwd_done,
	// CPU and pads
	input wire logic [15:0] pc,
	output logic break_request,
	input wire logic test_mode_pad,
	output logic flash_test_mode
);
	// ==========================================================
	// State
	dcd_state_type st_r, st_nxt;
	logic [7:0] ctl_r, opt_r, lcr_r, tm_r, op_r, cmd_r;
	logic en_r;
	logic [1:0] ops_left_r, rep_left_r;
	logic [15:0] reply_r;
	logic [12:0] brk_cnt_r;
	logic pad_s1_r, pad_s2_r, ftm_r;
	logic fwd_valid_r, fwd_en_r, fwd_po_r;
	logic [7:0] fwd_cmd_r;
	logic [31:0] prdata_r;
	logic [15:0] cnt;
	logic cnt_brk;
	// ==========================================================
	// Decode
	logic dbg, rp, iwp;
	logic g_known, g_en, g_fwd, g_po;
	logic [1:0] g_nops, g_nrep;
	logic rx_take, cmd_hit, last_op, tx_go, last_tx, wr_fire, load_rep;
	logic [7:0] cmd_now;
	logic en_now;
	logic [15:0] rep_raw, rep_val, op_word;
	logic [7:0] stat;
	assign dbg = ctl_r[CTL_DBG_BIT];
	assign rp = opt_r[OPT_RP_BIT];
	assign iwp = opt_r[OPT_IWP_BIT];
	assign rx_take = rx_valid & ~rx_err;
	assign cmd_hit = (st_r == ST_IDLE) & rx_take & g_known;
	assign last_op = (st_r == ST_OPER) & rx_take & (ops_left_r == 2'd1);
	assign tx_go = (st_r == ST_REPLY) & tx_ready;
	assign last_tx = tx_go & (rep_left_r == 2'd1);
	assign wr_fire = last_op & en_r;
	assign op_word = {op_r, rx_data};
	assign cmd_now = (st_r == ST_IDLE) ? rx_data : cmd_r;
	assign en_now = (st_r == ST_IDLE) ? g_en : en_r;
	assign stat = {dbg, 1'b0, rp, 4'h0, st_r == ST_FWD};
	assign load_rep = (cmd_hit & (g_nops == 2'd0) & (g_nrep != 2'd0)) |
		(last_op & (rep_left_r != 2'd0));
	dcd_gate u_gate (
		.code(rx_data),
		.dbg(dbg),
		.rp(rp),
		.known(g_known),
		.en(g_en),
		.fwd(g_fwd),
		.periph_only(g_po),
		.nops(g_nops),
		.nrep(g_nrep)
	);
	dcd_counter u_cnt (
		.pclk(pclk),
		.presetn(presetn),
		.load(wr_fire & (cmd_r == CMD_CNT_WR)),
		.load_val(op_word),
		.mode(dcd_cmode_type'(ctl_r[CTL_MODE_LSB+1:CTL_MODE_LSB])),
		.run(~dbg),
		.pc(pc),
		.cnt_r(cnt),
		.brk_r(cnt_brk)
	);
	// Reply word; single-byte replies sit in the high byte
	always_comb begin
		case (cmd_now)
			CMD_REV: rep_raw = REV_WORD;
			CMD_STAT_RD: rep_raw = {stat, 8'hff};
			CMD_CNT_RD: rep_raw = ~cnt;
			CMD_CTL_RD: rep_raw = {ctl_r, 8'hff};
			CMD_LCR_RD: rep_raw = {lcr_r, 8'hff};
			CMD_BAUD_RD: rep_raw = baud_reload;
			CMD_TM_RD: rep_raw = {tm_r, 8'hff};
			CMD_OPT_RD: rep_raw = (rx_data[4:0] == OPT_ADDR_USER0) ? {opt_r, 8'hff} : ALL_ONES;
			default: rep_raw = ALL_ONES;
		endcase
	end
	// A gated-off read answers all ones
	assign rep_val = en_now ? rep_raw : ALL_ONES;
	// ==========================================================
	// Sequencer
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (cmd_hit) begin
					if (g_fwd)
						st_nxt = ST_FWD;
					else if (g_nops != 2'd0)
						st_nxt = ST_OPER;
					else if (g_nrep != 2'd0)
						st_nxt = ST_REPLY;
				end
			end
			ST_OPER: if (last_op) st_nxt = (rep_left_r != 2'd0) ? ST_REPLY : ST_IDLE;
			ST_REPLY: if (last_tx) st_nxt = ST_IDLE;
			ST_FWD: if (fwd_done) st_nxt = ST_IDLE;
			ST_BRK: if (brk_cnt_r == 13'h0000) st_nxt = ST_IDLE;
			default: st_nxt = ST_IDLE;
		endcase
		if (rx_err)
			st_nxt = ST_BRK;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ST_IDLE;
			cmd_r <= 8'h00;
			en_r <= 1'b0;
			op_r <= 8'h00;
			ops_left_r <= 2'd0;
			rep_left_r <= 2'd0;
			reply_r <= ALL_ONES;
			brk_cnt_r <= 13'h0000;
		end else begin
			st_r <= st_nxt;
			if (cmd_hit) begin
				cmd_r <= rx_data;
				en_r <= g_en;
				ops_left_r <= g_nops;
				rep_left_r <= g_nrep;
			end else if (st_r == ST_OPER && rx_take) begin
				op_r <= rx_data;
				ops_left_r <= ops_left_r - 2'd1;
			end else if (tx_go) begin
				rep_left_r <= rep_left_r - 2'd1;
			end
			if (load_rep)
				reply_r <= rep_val;
			else if (tx_go)
				reply_r <= {reply_r[7:0], 8'hff};
			if (rx_err)
				brk_cnt_r <= BRK_CYCLES - 13'h0001;
			else if (st_r == ST_BRK)
				brk_cnt_r <= brk_cnt_r - 13'h0001;
		end
	end
	// ==========================================================
	// Debugger registers
	logic apb_wr, hit_ctrl, hit_stat, hit_opt, hit_cnt, mapped;
	logic [7:0] ctl_nxt, opt_nxt;
	logic opt_wr;
	assign apb_wr = psel & penable & pwrite;
	assign hit_ctrl = (paddr == ADDR_CTRL);
	assign hit_stat = (paddr == ADDR_STAT);
	assign hit_opt = (paddr == ADDR_OPT);
	assign hit_cnt = (paddr == ADDR_CNT);
	assign mapped = hit_ctrl | hit_stat | hit_opt | hit_cnt;
	assign opt_wr = wr_fire & (cmd_r == CMD_OPT_WR) & (op_r[4:0] == OPT_ADDR_USER0);
	// Protect bits survive a command option write while read protect is on; an APB write replaces them
	assign opt_nxt = rp ? {rx_data[7:2], opt_r[1:0]} : rx_data;
	// A counter break enters debug mode and wins over any clear
	always_comb begin
		ctl_nxt = ctl_r;
		if (apb_wr && hit_ctrl)
			ctl_nxt = pwdata[7:0];
		if (wr_fire && cmd_r == CMD_CTL_WR)
			ctl_nxt = rx_data;
		if (cnt_brk)
			ctl_nxt[CTL_DBG_BIT] = 1'b1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_r <= CTL_RST;
			opt_r <= OPT_RST;
			lcr_r <= LCR_RST;
			tm_r <= TM_RST;
		end else begin
			ctl_r <= ctl_nxt;
			if (opt_wr)
				opt_r <= opt_nxt;
			else if (apb_wr && hit_opt)
				opt_r <= pwdata[7:0];
			if (wr_fire && cmd_r == CMD_LCR_WR)
				lcr_r <= rx_data;
			if (wr_fire && cmd_r == CMD_TM_WR)
				tm_r <= rx_data;
		end
	end
	// ==========================================================
	// Pads, hand-off, APB read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_s1_r <= 1'b0;
			pad_s2_r <= 1'b0;
			ftm_r <= 1'b0;
			fwd_valid_r <= 1'b0;
			fwd_cmd_r <= 8'h00;
			fwd_en_r <= 1'b0;
			fwd_po_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pad_s1_r <= test_mode_pad;
			pad_s2_r <= pad_s1_r;
			ftm_r <= (pad_s2_r & ~rp) | (tm_r[TM_FLASH_BIT] & ~iwp);
			fwd_valid_r <= cmd_hit & g_fwd;
			if (cmd_hit && g_fwd) begin
				fwd_cmd_r <= rx_data;
				fwd_en_r <= g_en;
				fwd_po_r <= g_po;
			end
			// Latched in the setup phase so the data come from a register
			if (psel && !penable)
				prdata_r <= hit_ctrl ? {24'h0, ctl_r} : hit_stat ? {24'h0, stat} :
					hit_opt ? {24'h0, opt_r} : hit_cnt ? {16'h0, cnt} : 32'h0;
		end
	end
	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign tx_valid = (st_r == ST_REPLY);
	assign tx_data = reply_r[15:8];
	assign break_oe = (st_r == ST_BRK);
	assign lcr = lcr_r;
	assign fwd_valid = fwd_valid_r;
	assign fwd_cmd = fwd_cmd_r;
	assign fwd_enable = fwd_en_r;
	assign fwd_periph_only = fwd_po_r;
	assign break_request = cnt_brk;
	assign flash_test_mode = ftm_r;
	// ==========================================================
	// Assertions
	default clocking dcd_cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rev;
		(cmd_hit && rx_data == CMD_REV) |=> tx_valid && tx_data == REV_WORD[15:8];
	endproperty
	a_rev: assert property (p_rev) else $error("revision high byte wrong");
	property p_rev_lo;
		(tx_go && !last_tx && !rx_err && cmd_r == CMD_REV) |=> tx_data == REV_WORD[7:0];
	endproperty
	a_rev_lo: assert property (p_rev_lo) else $error("revision low byte wrong");
	property p_cnt_rd;
		(st_r == ST_IDLE && rx_take && rx_data == CMD_CNT_RD && !dbg) |=> reply_r == ALL_ONES;
	endproperty
	a_cnt_rd: assert property (p_cnt_rd) else $error("counter read not FFFF");
	// With the counter idle, any change can only come from a load
	property p_cnt_discard;
		(last_op && cmd_r == CMD_CNT_WR && !en_r &&
			ctl_r[CTL_MODE_LSB+1:CTL_MODE_LSB] == CM_OFF) |=> $stable(cnt);
	endproperty
	a_cnt_discard: assert property (p_cnt_discard) else $error("counter loaded outside debug");
	property p_brk;
		rx_err |=> break_oe && brk_cnt_r == BRK_CYCLES - 13'h0001;
	endproperty
	a_brk: assert property (p_brk) else $error("break not started");
	property p_brk_end;
		(break_oe && brk_cnt_r == 13'h0000 && !rx_err) |=> !break_oe && st_r == ST_IDLE;
	endproperty
	a_brk_end: assert property (p_brk_end) else $error("break length wrong");
	property p_unknown;
		(st_r == ST_IDLE && rx_take && !g_known) |=> st_r == ST_IDLE && !tx_valid && !fwd_valid;
	endproperty
	a_unknown: assert property (p_unknown) else $error("reserved code acted");
	property p_pad;
		(rp && !tm_r[TM_FLASH_BIT]) [*2] |=> !flash_test_mode;
	endproperty
	a_pad: assert property (p_pad) else $error("pad entered flash test");
	property p_iwp;
		(iwp && !pad_s2_r) [*2] |=> !flash_test_mode;
	endproperty
	a_iwp: assert property (p_iwp) else $error("test write entered flash test");
	property p_opt_keep;
		(opt_wr && rp) |=> opt_r[1:0] == $past(opt_r[1:0]);
	endproperty
	a_opt_keep: assert property (p_opt_keep) else $error("protect bits changed");
	property p_fwd_gate;
		fwd_valid && (!dbg || (rp && fwd_cmd != CMD_REG_WR && fwd_cmd != CMD_REG_RD &&
			fwd_cmd != CMD_CRC_RD)) |-> !fwd_enable;
	endproperty
	a_fwd_gate: assert property (p_fwd_gate) else $error("gated command enabled");
	c_rev: cover property (st_r == ST_IDLE && rx_take && rx_data == CMD_REV);
	c_cnt_wr: cover property (wr_fire && cmd_r == CMD_CNT_WR);
	c_brk: cover property (rx_err && st_r == ST_REPLY);
	c_fwd: cover property (fwd_valid && fwd_periph_only);
endmodule : dcd_top
`default_nettype wire

// *** src/dcd_pkg.sv ***
// Constants for the debug command decoder: command codes, APB map, field
// positions, reset values, counter modes and decoder states.
// Assumes one clock domain and a byte-level serial layer outside.
package dcd_pkg;
	// ==========================================================
	// Command codes
	localparam logic [7:0] CMD_REV = 8'h00;
	localparam logic [7:0] CMD_CNT_WR = 8'h01;
	localparam logic [7:0] CMD_STAT_RD = 8'h02;
	localparam logic [7:0] CMD_CNT_RD = 8'h03;
	localparam logic [7:0] CMD_CTL_WR = 8'h04;
	localparam logic [7:0] CMD_CTL_RD = 8'h05;
	localparam logic [7:0] CMD_PC_WR = 8'h06;
	localparam logic [7:0] CMD_PC_RD = 8'h07;
	localparam logic [7:0] CMD_REG_WR = 8'h08;
	localparam logic [7:0] CMD_REG_RD = 8'h09;
	localparam logic [7:0] CMD_PM_WR = 8'h0a;
	localparam logic [7:0] CMD_PM_RD = 8'h0b;
	localparam logic [7:0] CMD_DM_WR = 8'h0c;
	localparam logic [7:0] CMD_DM_RD = 8'h0d;
	localparam logic [7:0] CMD_CRC_RD = 8'h0e;
	localparam logic [7:0] CMD_STEP = 8'h10;
	localparam logic [7:0] CMD_STUFF = 8'h11;
	localparam logic [7:0] CMD_EXEC = 8'h12;
	localparam logic [7:0] CMD_LCR_WR = 8'h18;
	localparam logic [7:0] CMD_LCR_RD = 8'h19;
	localparam logic [7:0] CMD_BAUD_RD = 8'h1b;
	localparam logic [7:0] CMD_TM_WR = 8'hf0;
	localparam logic [7:0] CMD_TM_RD = 8'hf1;
	localparam logic [7:0] CMD_OPT_WR = 8'hf2;
	localparam logic [7:0] CMD_OPT_RD = 8'hf3;
	// ==========================================================
	// APB map
	localparam int APB_AW = 12;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STAT = 12'h004;
	localparam logic [11:0] ADDR_OPT = 12'h008;
	localparam logic [11:0] ADDR_CNT = 12'h00c;
	// ==========================================================
	// Fields and reset values
	localparam int CTL_DBG_BIT = 7;
	localparam int CTL_MODE_LSB = 4;
	localparam int OPT_RP_BIT = 0;
	localparam int OPT_IWP_BIT = 1;
	localparam int TM_FLASH_BIT = 0;
	localparam logic [4:0] OPT_ADDR_USER0 = 5'h00;
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] OPT_RST = 8'h00;
	localparam logic [7:0] LCR_RST = 8'h00;
	localparam logic [7:0] TM_RST = 8'h00;
	localparam logic [15:0] ALL_ONES = 16'hffff;
	// Abort break length in system clocks
	localparam logic [12:0] BRK_CYCLES = 13'h1000;
	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		CM_OFF = 2'b00,
		CM_CYCLES = 2'b01,
		CM_ZERO = 2'b10,
		CM_PCMATCH = 2'b11
	} dcd_cmode_type;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_OPER = 3'b001,
		ST_REPLY = 3'b010,
		ST_FWD = 3'b011,
		ST_BRK = 3'b100
	} dcd_state_type;
endpackage : dcd_pkg

// *** src/dcd_gate.sv ***
// Command gate: classifies a command byte and decides if it may act.
// Assumes debug mode and read-protect levels from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module dcd_gate
	import dcd_pkg::*;
(
	// Inputs
	input wire logic [7:0] code,
	input wire logic dbg,
	input wire logic rp,
	// Classification
	output logic known,
	output logic en,
	output logic fwd,
	output logic periph_only,
	output logic [1:0] nops,
	output logic [1:0] nrep
);
	logic en_nd;
	logic rp_blk;

	always_comb begin
		known = 1'b1;
		en_nd = 1'b0;
		rp_blk = 1'b0;
		fwd = 1'b0;
		nops = 2'd0;
		nrep = 2'd0;
		case (code)
			CMD_REV: begin en_nd = 1'b1; nrep = 2'd2; end
			CMD_CNT_WR: nops = 2'd2;
			CMD_STAT_RD: begin en_nd = 1'b1; nrep = 2'd1; end
			CMD_CNT_RD: nrep = 2'd2;
			CMD_CTL_WR: begin en_nd = 1'b1; nops = 2'd1; end
			CMD_CTL_RD: begin en_nd = 1'b1; nrep = 2'd1; end
			CMD_PC_WR, CMD_PC_RD, CMD_PM_WR, CMD_PM_RD, CMD_DM_WR, CMD_DM_RD,
			CMD_STEP, CMD_STUFF, CMD_EXEC: begin fwd = 1'b1; rp_blk = 1'b1; end
			CMD_REG_WR, CMD_REG_RD, CMD_CRC_RD: fwd = 1'b1;
			CMD_LCR_WR, CMD_TM_WR: nops = 2'd1;
			CMD_LCR_RD, CMD_TM_RD: nrep = 2'd1;
			CMD_BAUD_RD: nrep = 2'd2;
			CMD_OPT_WR: nops = 2'd2;
			CMD_OPT_RD: begin nops = 2'd1; nrep = 2'd1; end
			default: known = 1'b0;
		endcase
	end

	// Outside debug mode only the open subset acts; protect blocks its list
	assign en = known & (dbg | en_nd) & ~(rp & rp_blk);
	// Register access under protect is limited to peripheral space
	assign periph_only = rp & ((code == CMD_REG_WR) | (code == CMD_REG_RD));
endmodule : dcd_gate
`default_nettype wire

// *** src/dcd_counter.sv ***
// Debug counter: 16-bit down counter with cycle, zero-break and PC-match modes.
// Assumes run is high while the CPU executes outside debug mode.
`timescale 1ns/1ps
`default_nettype none
module dcd_counter
	import dcd_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic load,
	input wire logic [15:0] load_val,
	input wire dcd_pkg::dcd_cmode_type mode,
	input wire logic run,
	input wire logic [15:0] pc,
	// Results
	output logic [15:0] cnt_r,
	output logic brk_r
);
	logic run_d_r;
	logic start;
	logic nonzero;
	logic dec;

	assign start = run & ~run_d_r;
	assign nonzero = (cnt_r != 16'h0000);
	// Counts down from full so the inverted read looks like an up count
	assign dec = run & nonzero & ((mode == CM_CYCLES) | (mode == CM_ZERO));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 16'h0000;
			run_d_r <= 1'b0;
			brk_r <= 1'b0;
		end else begin
			run_d_r <= run;
			if (load)
				cnt_r <= load_val;
			else if (start && mode == CM_CYCLES)
				cnt_r <= ALL_ONES;
			else if (dec)
				cnt_r <= cnt_r - 16'h0001;
			brk_r <= run & (((mode == CM_ZERO) & (cnt_r == 16'h0001)) |
				((mode == CM_PCMATCH) & (pc == cnt_r)));
		end
	end
endmodule : dcd_counter
`default_nettype wire

// *** test/dcd_host.sv ***
// Host-side model of the byte link: sends command and operand bytes as
// one-cycle pulses, raises line faults, and collects reply bytes.
// Assumes the decoder samples every link signal on the rising pclk edge.
`timescale 1ns/1ps
`default_nettype none
module dcd_host (
	// Clock
	input wire logic pclk,
	// When high, ready is offered only every other cycle
	input wire logic slow,
	// Byte link
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_err,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready
);
	logic [7:0] q[$];
	logic ph;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_err = 1'b0;
		tx_ready = 1'b0;
		ph = 1'b0;
	end
	// ==========
	// Sending
	// Idle data shows the inverse of the last byte, so a stale byte is never taken
	task automatic send(input logic [7:0] b);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_data <= b;
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_data <= ~b;
	endtask : send
	task automatic line_fault();
		@(posedge pclk);
		rx_err <= 1'b1;
		@(posedge pclk);
		rx_err <= 1'b0;
	endtask : line_fault
	// ==========
	// Receiving: every byte offered while ready is high goes into the queue
	always @(posedge pclk) begin
		ph <= ~ph;
		tx_ready <= ~slow | ph;
		if (tx_valid && tx_ready) begin
			q.push_back(tx_data);
		end
	end
endmodule : dcd_host
`default_nettype wire

// *** test/tb_debug_command_decoder.sv ***
// Self-checking bench for the debug command decoder: APB master, host byte
// model, neighbour handshake for forwarded commands.
// Assumes the decoder and the host model share the one pclk.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
	$display("wrong value %s expected %h seen %h", nm, e, g); bad_count++; end end
module tb_debug_command_decoder;
	import dcd_pkg::*;
	typedef struct {
		logic [7:0] ctl; logic [7:0] opt; logic [7:0] cmd; int nop;
		logic [15:0] ops; int nrep; logic [15:0] exp;
	} dcd_row_type;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic rx_valid, rx_err, tx_valid, tx_ready, break_oe, fwd_valid, fwd_enable;
	logic [7:0] rx_data, tx_data, lcr, fwd_cmd, fc;
	logic fwd_periph_only, fwd_done, break_request, test_mode_pad, flash_test_mode, er;
	logic [15:0] baud_reload, pc;
	int bad_count, checked, cycles, fwd_seen, brk_seen, n, b0;
	dcd_row_type rows[25] = '{
		'{8'h00,8'h00,8'h00,0,16'h0000,2,16'h0100}, '{8'h00,8'h00,8'h02,0,16'h0000,1,16'h0000},
		'{8'h80,8'h01,8'h02,0,16'h0000,1,16'h00a0}, '{8'h80,8'h00,8'h01,2,16'h1234,0,16'h0000},
		'{8'h80,8'h00,8'h03,0,16'h0000,2,16'hedcb}, '{8'h00,8'h00,8'h01,2,16'h5555,0,16'h0000},
		'{8'h00,8'h00,8'h03,0,16'h0000,2,16'hffff}, '{8'h80,8'h00,8'h03,0,16'h0000,2,16'hedcb},
		'{8'h00,8'h00,8'h04,1,16'h0080,0,16'h0000}, '{8'hff,8'h00,8'h05,0,16'h0000,1,16'h0080},
		'{8'h00,8'h00,8'h19,0,16'h0000,1,16'h00ff}, '{8'h00,8'h00,8'h18,1,16'h005a,0,16'h0000},
		'{8'h80,8'h00,8'h19,0,16'h0000,1,16'h0000}, '{8'h80,8'h00,8'h18,1,16'h005a,0,16'h0000},
		'{8'h80,8'h00,8'h19,0,16'h0000,1,16'h005a}, '{8'h80,8'h00,8'h1b,0,16'h0000,2,16'hc3a5},
		'{8'h00,8'h00,8'h1b,0,16'h0000,2,16'hffff}, '{8'h80,8'h00,8'h0f,0,16'h0000,0,16'h0000},
		'{8'h80,8'h00,8'h55,0,16'h0000,0,16'h0000}, '{8'h80,8'h01,8'hf3,1,16'h0000,1,16'h0001},
		'{8'h80,8'h00,8'hf1,0,16'h0000,1,16'h0000}, '{8'h80,8'h01,8'hf2,2,16'h0002,0,16'h0000},
		'{8'hff,8'h00,8'hf3,1,16'h0000,1,16'h0001}, '{8'h80,8'h00,8'hf2,2,16'h0002,0,16'h0000},
		'{8'hff,8'h00,8'hf3,1,16'h0000,1,16'h0002}};
	logic [7:0] fcodes[12] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d,
		8'h0e, 8'h10, 8'h11, 8'h12};
	dcd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .break_oe(break_oe),
		.baud_reload(baud_reload), .lcr(lcr), .fwd_valid(fwd_valid), .fwd_cmd(fwd_cmd),
		.fwd_enable(fwd_enable), .fwd_periph_only(fwd_periph_only), .fwd_done(fwd_done),
		.pc(pc), .break_request(break_request), .test_mode_pad(test_mode_pad),
		.flash_test_mode(flash_test_mode));
	dcd_host host (.pclk(pclk), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_err(rx_err), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
	// ==========
	// Clock, pulse monitors and hang guard
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// fwd_valid lasts one cycle and break_request up to two, so they are counted rather than polled
	always @(posedge pclk) begin
		cycles++;
		if (fwd_valid === 1'b1) fwd_seen++;
		if (break_request === 1'b1) brk_seen++;
		if (cycles == 30000) begin
			bad_count++;
			give_verdict();
		end
	end
	// ==========
	// Tasks
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Answer is taken at the rising edge where ready is seen
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// A control value of ff keeps the present mode and options
	task automatic setmode(input logic [7:0] c, input logic [7:0] o);
		if (c !== 8'hff) begin
			apb(1'b1, ADDR_OPT, {24'h0, o});
			apb(1'b1, ADDR_CTRL, {24'h0, c});
		end
	endtask : setmode
	task automatic run_cmd(input dcd_row_type r);
		int k;
		k = 0;
		host.q.delete();
		host.send(r.cmd);
		if (r.nop == 2) host.send(r.ops[15:8]);
		if (r.nop > 0) host.send(r.ops[7:0]);
		while (host.q.size() < r.nrep && k < 40) begin
			@(posedge pclk);
			k++;
		end
		// Extra cycles let any surplus reply byte show up
		repeat (6) @(posedge pclk);
		`CHK("reply count", r.nrep, host.q.size())
		if (r.nrep == 2 && host.q.size() == 2) `CHK("reply", r.exp, {host.q[0], host.q[1]})
		if (r.nrep == 1 && host.q.size() == 1) `CHK("reply", r.exp[7:0], host.q[0])
	endtask : run_cmd
	// ==========
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, fwd_done, test_mode_pad, slow} = 7'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		baud_reload = 16'hc3a5;
		pc = 16'h0040;
		repeat (12) @(posedge pclk);
		`CHK("tx_valid in reset", 1'b0, tx_valid)
		`CHK("break_oe in reset", 1'b0, break_oe)
		`CHK("flash test in reset", 1'b0, flash_test_mode)
		presetn <= 1'b1;
		apb(1'b0, ADDR_CTRL, 32'h0);
		`CHK("control reset", 32'h0, rd)
		apb(1'b0, ADDR_OPT, 32'h0);
		`CHK("option reset", 32'h0, rd)
		`CHK("lcr reset", 8'h00, lcr)
		apb(1'b1, ADDR_STAT, 32'hffff);
		apb(1'b0, ADDR_STAT, 32'h0);
		`CHK("status read only", 32'h0, rd)
		apb(1'b0, 12'h010, 32'h0);
		`CHK("unmapped error", 1'b1, er)
		$display("test reset and map done");
		foreach (rows[i]) begin
			slow <= ~slow;
			setmode(rows[i].ctl, rows[i].opt);
			run_cmd(rows[i]);
		end
		`CHK("line control out", 8'h5a, lcr)
		$display("test command rows done");
		for (int p = 0; p < 2; p++) begin
			setmode(p ? 8'h80 : 8'h00, p ? 8'h01 : 8'h00);
			foreach (fcodes[i]) begin
				fc = fcodes[i];
				b0 = fwd_seen;
				host.send(fc);
				n = 0;
				while (fwd_seen == b0 && n < 20) begin
					@(negedge pclk);
					n++;
				end
				`CHK("forward code", fc, fwd_cmd)
				`CHK("forward enable", p == 1 && fc inside {8'h08, 8'h09, 8'h0e}, fwd_enable)
				`CHK("peripheral only", p == 1 && fc inside {8'h08, 8'h09}, fwd_periph_only)
				@(posedge pclk);
				fwd_done <= 1'b1;
				@(posedge pclk);
				fwd_done <= 1'b0;
			end
		end
		$display("test forwarding done");
		test_mode_pad <= 1'b1;
		setmode(8'h80, 8'h01);
		repeat (6) @(posedge pclk);
		`CHK("pad under protect", 1'b0, flash_test_mode)
		setmode(8'h80, 8'h00);
		repeat (6) @(posedge pclk);
		`CHK("pad open", 1'b1, flash_test_mode)
		test_mode_pad <= 1'b0;
		run_cmd('{8'h80, 8'h00, 8'hf0, 1, 16'h0000, 0, 16'h0000});
		setmode(8'h80, 8'h02);
		run_cmd('{8'h80, 8'h02, 8'hf0, 1, 16'h0001, 0, 16'h0000});
		`CHK("test write info protect", 1'b0, flash_test_mode)
		run_cmd('{8'h80, 8'h02, 8'hf0, 1, 16'h0000, 0, 16'h0000});
		setmode(8'h80, 8'h00);
		@(negedge pclk);
		`CHK("test mode cleared", 1'b0, flash_test_mode)
		run_cmd('{8'h80, 8'h00, 8'hf0, 1, 16'h0001, 0, 16'h0000});
		`CHK("test write open", 1'b1, flash_test_mode)
		run_cmd('{8'h80, 8'h00, 8'hf0, 1, 16'h0000, 0, 16'h0000});
		$display("test flash test mode done");
		for (int m = 1; m < 4; m++) begin
			setmode({2'b10, 2'(m), 4'h0}, 8'h00);
			run_cmd('{8'h80, 8'h00, 8'h01, 2, m == 2 ? 16'h0003 : 16'h0040, 0, 16'h0000});
			b0 = brk_seen;
			apb(1'b1, ADDR_CTRL, {26'h0, 2'(m), 4'h0});
			n = 0;
			while (brk_seen == b0 && n < 30) begin
				@(negedge pclk);
				n++;
			end
			`CHK("counter break", m != 1, brk_seen != b0)
			// Cycle mode restarts from full on leaving debug and counts down
			if (m == 1) begin
				apb(1'b0, ADDR_CNT, 32'h0);
				`CHK("cycle count", 1'b1, rd[15:0] < ALL_ONES && rd[15:0] > 16'hff00)
			end
			apb(1'b0, ADDR_CTRL, 32'h0);
			`CHK("break enters debug", m != 1, rd[7])
		end
		$display("test counter breaks done");
		setmode(8'h00, 8'h00);
		host.send(CMD_CNT_WR);
		host.line_fault();
		n = 0;
		while (break_oe !== 1'b1 && n < 10) begin
			@(negedge pclk);
			n++;
		end
		n = 0;
		while (break_oe === 1'b1 && n < 5000) begin
			@(negedge pclk);
			n++;
		end
		`CHK("break length", 4096, n)
		run_cmd(rows[0]);
		$display("test line fault done");
		give_verdict();
	end
endmodule : tb_debug_command_decoder
`default_nettype wire
